/* inc/acfg_pkg.sv */
// constants, field layouts and state types of the configuration register bank
package acfg_pkg;

  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] ADDR_IDENTITY = 13'h0001;
  localparam logic [12:0] ADDR_GRADE = 13'h0002;
  localparam logic [12:0] ADDR_SEL_UPPER = 13'h0004;
  localparam logic [12:0] ADDR_SEL_LOWER = 13'h0005;
  localparam logic [12:0] ADDR_MODES = 13'h0008;
  localparam logic [12:0] ADDR_CLOCK = 13'h0009;
  localparam logic [12:0] ADDR_TRANSFER = 13'h00ff;

  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] GRADE_RST = 8'h00;
  localparam logic [7:0] SEL_UPPER_RST = 8'h0f;
  localparam logic [7:0] SEL_LOWER_RST = 8'h0f;
  localparam logic [7:0] MODES_RST = 8'h00;
  localparam logic [7:0] CLOCK_RST = 8'h01;
  localparam logic [7:0] TRANSFER_RST = 8'h00;

  // bit positions: mirrored nibbles of the port configuration, then single field bits
  localparam int PORT_LSB_HI = 6;
  localparam int PORT_LSB_LO = 1;
  localparam int PORT_SRST_HI = 5;
  localparam int PORT_SRST_LO = 2;
  localparam int GRADE_LSB = 4;
  localparam int MODE_BYPASS_BIT = 3;
  localparam int CLK_DCS_BIT = 0;
  localparam int XFER_BIT = 0;

  // lanes 0..7 data channels A..H, then word clock, then bit clock
  localparam int LANES = 10;
  localparam int LANE_WORD_CLK = 8;
  localparam int LANE_BIT_CLK = 9;

  // serial instruction layout
  localparam int INSTR_BITS = 16;
  localparam int INSTR_READ_BIT = 15;
  localparam int INSTR_LEN_HI = 14;
  localparam int INSTR_LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_FULL_PDWN = 3'h1,
    MODE_STANDBY = 3'h2,
    MODE_RESET = 3'h3,
    MODE_CW = 3'h4
  } acfg_mode_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'h0,
    SP_INSTR = 2'h1,
    SP_DATA = 2'h3
  } acfg_spi_state_t;

endpackage

/* verilog/acfg_serial_port.sv */
// serial control port: pin sampling, framing, write strobes and readback shifting
`timescale 1ns/1ps
module acfg_serial_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclkPin,
  input wire logic serialSelectN,
  input wire logic sdioIn,
  input wire logic lsbFirst,
  input wire logic [7:0] rdData,
  output logic [12:0] regAddr,
  output logic wrEn,
  output logic [12:0] wrAddr,
  output logic [7:0] wrData,
  output logic sdioOut,
  output logic sdioOe
);
  // order in the sync vectors: sclk, select, data
  logic [2:0] meta_q, sync_q;
  logic sclkLast_q;
  acfg_pkg::acfg_spi_state_t state_q, state_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [15:0] rx_q, rx_d;
  logic isRead_q, isRead_d, stream_q, stream_d;
  logic [1:0] left_q, left_d;
  logic [12:0] addr_q, addr_d, wrAddr_q, wrAddr_d;
  logic [7:0] tx_q, tx_d, wrData_q, wrData_d;
  logic wrEn_q, wrEn_d, out_q, out_d, oe_q, oe_d;
  logic rise, fall, selHigh, dataBit;

  assign selHigh = sync_q[1];
  assign dataBit = sync_q[0];
  assign rise = sync_q[2] & ~sclkLast_q & ~selHigh;
  assign fall = ~sync_q[2] & sclkLast_q & ~selHigh;

  always_comb
  begin
    logic [3:0] iIdx;
    logic [2:0] dIdx;
    logic [15:0] full;
    iIdx = lsbFirst ? bitCnt_q : 4'hf - bitCnt_q;
    dIdx = lsbFirst ? bitCnt_q[2:0] : 3'h7 - bitCnt_q[2:0];
    full = rx_q;
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    rx_d = rx_q;
    isRead_d = isRead_q;
    stream_d = stream_q;
    left_d = left_q;
    addr_d = addr_q;
    tx_d = tx_q;
    out_d = out_q;
    oe_d = oe_q;
    wrEn_d = 1'b0;
    wrAddr_d = wrAddr_q;
    wrData_d = wrData_q;
    if (selHigh)
    begin
      oe_d = 1'b0;
      // a short transfer may pause at a byte boundary; all else aborts
      if (!(state_q == acfg_pkg::SP_DATA && bitCnt_q == 4'h0 && !stream_q && left_q != 2'h0))
      begin
        state_d = acfg_pkg::SP_IDLE;
        bitCnt_d = 4'h0;
      end
    end
    else
    begin
      unique case (state_q)
        acfg_pkg::SP_IDLE:
        begin
          state_d = acfg_pkg::SP_INSTR;
          bitCnt_d = 4'h0;
        end
        acfg_pkg::SP_INSTR:
        begin
          if (rise)
          begin
            full[iIdx] = dataBit;
            rx_d = full;
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == 4'(acfg_pkg::INSTR_BITS - 1))
            begin
              isRead_d = full[acfg_pkg::INSTR_READ_BIT];
              stream_d = full[acfg_pkg::INSTR_LEN_HI:acfg_pkg::INSTR_LEN_LO] == acfg_pkg::LEN_STREAM;
              left_d = full[acfg_pkg::INSTR_LEN_HI:acfg_pkg::INSTR_LEN_LO] + 2'h1;
              addr_d = full[acfg_pkg::ADDR_W-1:0];
              bitCnt_d = 4'h0;
              state_d = acfg_pkg::SP_DATA;
            end
          end
        end
        acfg_pkg::SP_DATA:
        begin
          if (fall && isRead_q)
          begin
            oe_d = 1'b1;
            if (bitCnt_q == 4'h0)
            begin
              tx_d = rdData;
              out_d = lsbFirst ? rdData[0] : rdData[7];
            end
            else
            begin
              out_d = tx_q[dIdx];
            end
          end
          if (rise)
          begin
            full[dIdx] = dataBit;
            rx_d = full;
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h7)
            begin
              bitCnt_d = 4'h0;
              wrEn_d = ~isRead_q;
              wrAddr_d = addr_q;
              wrData_d = full[7:0];
              addr_d = lsbFirst ? addr_q + 13'h0001 : addr_q - 13'h0001;
              if (!stream_q)
              begin
                left_d = left_q - 2'h1;
                if (left_q == 2'h1)
                begin
                  state_d = acfg_pkg::SP_IDLE;
                end
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    meta_q <= {sclkPin, serialSelectN, sdioIn};
    sync_q <= meta_q;
    if (rst)
    begin
      sclkLast_q <= 1'b0;
      state_q <= acfg_pkg::SP_IDLE;
      bitCnt_q <= 4'h0;
      rx_q <= 16'h0000;
      isRead_q <= 1'b0;
      stream_q <= 1'b0;
      left_q <= 2'h0;
      addr_q <= 13'h0000;
      tx_q <= 8'h00;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      wrEn_q <= 1'b0;
      wrAddr_q <= 13'h0000;
      wrData_q <= 8'h00;
    end
    else
    begin
      sclkLast_q <= sync_q[2];
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      rx_q <= rx_d;
      isRead_q <= isRead_d;
      stream_q <= stream_d;
      left_q <= left_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      out_q <= out_d;
      oe_q <= oe_d;
      wrEn_q <= wrEn_d;
      wrAddr_q <= wrAddr_d;
      wrData_q <= wrData_d;
    end
  end

  assign regAddr = addr_q;
  assign wrEn = wrEn_q;
  assign wrAddr = wrAddr_q;
  assign wrData = wrData_q;
  assign sdioOut = out_q;
  assign sdioOe = oe_q;
endmodule

/* verilog/acfg_register_map.sv */
// configuration register bank with shadow/live lane settings behind the serial port
`timescale 1ns/1ps
module acfg_register_map #(
  // identity value is arbitrary
  parameter logic [7:0] IDENTITY_CODE = 8'h5a,
  parameter logic [1:0] SPEED_GRADE = 2'h0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclkPin,
  input wire logic serialSelectN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic [9:0] laneFullPowerdown,
  output logic [9:0] laneStandby,
  output logic [9:0] laneHeldReset,
  output logic [9:0] laneContinuousWave,
  output logic [9:0] gainPathPowerdown,
  output logic [9:0] laneLnaBypass,
  output logic dutyCycleStabiliserOn
);
  localparam int LANES = acfg_pkg::LANES;

  logic wrEn;
  logic [12:0] wrAddr, regAddr;
  logic [7:0] wrData, rdData;

  logic lsbFirst_q, lsbFirst_d;
  logic softReset_q, softReset_d;
  logic shadowCopyStrobe_q, shadowCopyStrobe_d;
  logic [3:0] selUpper_q, selUpper_d;
  logic [5:0] selLower_q, selLower_d;
  logic dcsShadow_q, dcsShadow_d;
  logic dcsLive_q, dcsLive_d;
  logic dcsOut_q;

  logic [LANES-1:0] laneSel;
  logic [LANES-1:0][3:0] laneShadow;

  acfg_serial_port u_port (
    .clock(clock),
    .rst(rst),
    .sclkPin(sclkPin),
    .serialSelectN(serialSelectN),
    .sdioIn(sdioIn),
    .lsbFirst(lsbFirst_q),
    .rdData(rdData),
    .regAddr(regAddr),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .sdioOut(sdioOut),
    .sdioOe(sdioOe)
  );

  // lane order: A..D, E..H, word clock, bit clock
  assign laneSel = {selLower_q[5], selLower_q[4], selUpper_q, selLower_q[3:0]};

  // chip-level configuration
  always_comb
  begin
    lsbFirst_d = lsbFirst_q;
    softReset_d = 1'b0;
    shadowCopyStrobe_d = 1'b0;
    selUpper_d = selUpper_q;
    selLower_d = selLower_q;
    dcsShadow_d = dcsShadow_q;
    dcsLive_d = dcsLive_q;
    if (softReset_q)
    begin
      lsbFirst_d = acfg_pkg::PORT_CFG_RST[acfg_pkg::PORT_LSB_HI];
      selUpper_d = acfg_pkg::SEL_UPPER_RST[3:0];
      selLower_d = acfg_pkg::SEL_LOWER_RST[5:0];
      dcsShadow_d = acfg_pkg::CLOCK_RST[acfg_pkg::CLK_DCS_BIT];
      dcsLive_d = acfg_pkg::CLOCK_RST[acfg_pkg::CLK_DCS_BIT];
    end
    else
    begin
      if (wrEn)
      begin
        case (wrAddr)
          acfg_pkg::ADDR_PORT_CFG:
          begin
            // either mirrored nibble sets the flag
            lsbFirst_d = wrData[acfg_pkg::PORT_LSB_HI] | wrData[acfg_pkg::PORT_LSB_LO];
            softReset_d = wrData[acfg_pkg::PORT_SRST_HI] | wrData[acfg_pkg::PORT_SRST_LO];
          end
          acfg_pkg::ADDR_SEL_UPPER:
          begin
            selUpper_d = wrData[3:0];
          end
          acfg_pkg::ADDR_SEL_LOWER:
          begin
            selLower_d = wrData[5:0];
          end
          acfg_pkg::ADDR_CLOCK:
          begin
            dcsShadow_d = wrData[acfg_pkg::CLK_DCS_BIT];
          end
          acfg_pkg::ADDR_TRANSFER:
          begin
            shadowCopyStrobe_d = wrData[acfg_pkg::XFER_BIT];
          end
          default:
          begin
          end
        endcase
      end
      if (shadowCopyStrobe_q)
      begin
        dcsLive_d = dcsShadow_q;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lsbFirst_q <= acfg_pkg::PORT_CFG_RST[acfg_pkg::PORT_LSB_HI];
      softReset_q <= 1'b0;
      shadowCopyStrobe_q <= acfg_pkg::TRANSFER_RST[acfg_pkg::XFER_BIT];
      selUpper_q <= acfg_pkg::SEL_UPPER_RST[3:0];
      selLower_q <= acfg_pkg::SEL_LOWER_RST[5:0];
      dcsShadow_q <= acfg_pkg::CLOCK_RST[acfg_pkg::CLK_DCS_BIT];
      dcsLive_q <= acfg_pkg::CLOCK_RST[acfg_pkg::CLK_DCS_BIT];
      dcsOut_q <= acfg_pkg::CLOCK_RST[acfg_pkg::CLK_DCS_BIT];
    end
    else
    begin
      lsbFirst_q <= lsbFirst_d;
      softReset_q <= softReset_d;
      shadowCopyStrobe_q <= shadowCopyStrobe_d;
      selUpper_q <= selUpper_d;
      selLower_q <= selLower_d;
      dcsShadow_q <= dcsShadow_d;
      dcsLive_q <= dcsLive_d;
      dcsOut_q <= dcsLive_q;
    end
  end

  assign dutyCycleStabiliserOn = dcsOut_q;

  // per-lane mode and bypass, shadowed then decoded to control flops
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    logic [3:0] shadow_q, shadow_d, live_q, live_d;
    logic pdwn_q, stby_q, hold_q, cw_q, bypass_q;
    logic pdwn_d, stby_d, hold_d, cw_d, bypass_d;
    acfg_pkg::acfg_mode_t mode;

    assign mode = acfg_pkg::acfg_mode_t'(live_q[2:0]);

    always_comb
    begin
      shadow_d = shadow_q;
      live_d = live_q;
      if (softReset_q)
      begin
        shadow_d = acfg_pkg::MODES_RST[3:0];
        live_d = acfg_pkg::MODES_RST[3:0];
      end
      else
      begin
        if (wrEn && wrAddr == acfg_pkg::ADDR_MODES && laneSel[i])
        begin
          shadow_d = wrData[3:0];
        end
        if (shadowCopyStrobe_q)
        begin
          live_d = shadow_q;
        end
      end
      // codes above continuous wave have no function and run normally
      pdwn_d = mode == acfg_pkg::MODE_FULL_PDWN;
      stby_d = mode == acfg_pkg::MODE_STANDBY;
      hold_d = mode == acfg_pkg::MODE_RESET;
      cw_d = mode == acfg_pkg::MODE_CW;
      bypass_d = live_q[acfg_pkg::MODE_BYPASS_BIT];
    end

    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        shadow_q <= acfg_pkg::MODES_RST[3:0];
        live_q <= acfg_pkg::MODES_RST[3:0];
        pdwn_q <= 1'b0;
        stby_q <= 1'b0;
        hold_q <= 1'b0;
        cw_q <= 1'b0;
        bypass_q <= 1'b0;
      end
      else
      begin
        shadow_q <= shadow_d;
        live_q <= live_d;
        pdwn_q <= pdwn_d;
        stby_q <= stby_d;
        hold_q <= hold_d;
        cw_q <= cw_d;
        bypass_q <= bypass_d;
      end
    end

    assign laneShadow[i] = shadow_q;
    assign laneFullPowerdown[i] = pdwn_q;
    assign laneStandby[i] = stby_q;
    assign laneHeldReset[i] = hold_q;
    assign laneContinuousWave[i] = cw_q;
    assign gainPathPowerdown[i] = cw_q;
    assign laneLnaBypass[i] = bypass_q;
  end

  // readback; mode register shows the lowest selected lane
  always_comb
  begin
    logic [3:0] pick;
    pick = laneShadow[0];
    for (int k = LANES - 1; k >= 0; k--)
    begin
      if (laneSel[k])
      begin
        pick = laneShadow[k];
      end
    end
    case (regAddr)
      acfg_pkg::ADDR_PORT_CFG:
        rdData = acfg_pkg::PORT_CFG_RST
          | {1'b0, lsbFirst_q, 4'h0, lsbFirst_q, 1'b0};
      acfg_pkg::ADDR_IDENTITY:
        rdData = IDENTITY_CODE;
      acfg_pkg::ADDR_GRADE:
        rdData = acfg_pkg::GRADE_RST | {2'h0, SPEED_GRADE, 4'h0};
      acfg_pkg::ADDR_SEL_UPPER:
        rdData = {4'h0, selUpper_q};
      acfg_pkg::ADDR_SEL_LOWER:
        rdData = {2'h0, selLower_q};
      acfg_pkg::ADDR_MODES:
        rdData = {4'h0, pick};
      acfg_pkg::ADDR_CLOCK:
        rdData = {7'h00, dcsShadow_q};
      acfg_pkg::ADDR_TRANSFER:
        rdData = {7'h00, shadowCopyStrobe_q};
      default:
        rdData = 8'h00;
    endcase
  end
endmodule

/* verification/acfg_checker.sv */
// port assertions for the configuration register bank
`timescale 1ns/1ps
module acfg_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclkPin,
  input wire logic serialSelectN,
  input wire logic sdioOut,
  input wire logic sdioOe,
  input wire logic [9:0] laneFullPowerdown,
  input wire logic [9:0] laneStandby,
  input wire logic [9:0] laneHeldReset,
  input wire logic [9:0] laneContinuousWave,
  input wire logic [9:0] gainPathPowerdown,
  input wire logic [9:0] laneLnaBypass,
  input wire logic dutyCycleStabiliserOn
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [9:0] anyMode;
  logic [9:0] overlap;
  assign anyMode = laneFullPowerdown | laneStandby | laneHeldReset | laneContinuousWave;
  assign overlap = (laneFullPowerdown & (laneStandby | laneHeldReset | laneContinuousWave))
    | (laneStandby & (laneHeldReset | laneContinuousWave)) | (laneHeldReset & laneContinuousWave);
  // host has left the port alone for a while
  sequence selectIdle;
    serialSelectN [*8];
  endsequence
  AST_RESET_MODES: assert property ($fell(rst) |-> anyMode == 10'h000 && laneLnaBypass == 10'h000)
    else $error("lane modes not cleared by reset");
  AST_RESET_DCS: assert property ($fell(rst) |-> dutyCycleStabiliserOn)
    else $error("stabiliser not on after reset");
  AST_ONE_MODE: assert property (overlap == 10'h000)
    else $error("lane in two modes at once");
  AST_CW_GAIN: assert property (laneContinuousWave == gainPathPowerdown)
    else $error("gain path not tied to continuous wave");
  AST_LIVE_HOLD: assert property (selectIdle |=> $stable(anyMode) && $stable(laneLnaBypass)
    && $stable(dutyCycleStabiliserOn))
    else $error("live setting moved with port idle");
  AST_OE_IDLE: assert property (selectIdle |-> !sdioOe)
    else $error("data pin driven outside a frame");
  AST_OE_RISE: assert property ($rose(sdioOe) |-> !sclkPin && !serialSelectN)
    else $error("data pin turned round at wrong time");
  AST_OUT_STEADY: assert property (sdioOe && $past(sdioOe) && $changed(sdioOut) |-> !sclkPin)
    else $error("read data moved while serial clock high");
endmodule
bind acfg_register_map acfg_checker acfg_checker_inst (.clock(clock), .rst(rst),
  .sclkPin(sclkPin), .serialSelectN(serialSelectN), .sdioOut(sdioOut), .sdioOe(sdioOe),
  .laneFullPowerdown(laneFullPowerdown), .laneStandby(laneStandby),
  .laneHeldReset(laneHeldReset), .laneContinuousWave(laneContinuousWave),
  .gainPathPowerdown(gainPathPowerdown), .laneLnaBypass(laneLnaBypass),
  .dutyCycleStabiliserOn(dutyCycleStabiliserOn));

/* verification/acfg_host_model.sv */
// host serial controller that frames single byte transfers and msb-first write frames of up to 16 data bits
`timescale 1ns/1ps
module acfg_host_model (
  input wire logic clock,
  input wire logic sdioOut,
  input wire logic sdioOe,
  output logic sclkPin,
  output logic serialSelectN,
  output logic sdioIn
);
  logic lsbMode;
  logic hostDrive;
  logic hostBit;
  // released and undriven pin shows the inverse level
  assign sdioIn = sdioOe ? sdioOut : (hostDrive ? hostBit : ~sdioOut);
  initial
  begin
    lsbMode = 1'b0;
    hostDrive = 1'b0;
    hostBit = 1'b0;
    sclkPin = 1'b0;
    serialSelectN = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // slow clock halves so the synchronisers see each edge
  task automatic shift(input logic b, output logic r);
    hostBit = b;
    tick(6);
    r = sdioIn;
    sclkPin = 1'b1;
    tick(6);
    sclkPin = 1'b0;
  endtask
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
    output logic [7:0] q);
    logic [15:0] ins;
    logic r;
    ins = {rd, 2'h0, a};
    serialSelectN = 1'b0;
    hostDrive = 1'b1;
    tick(6);
    for (int i = 0; i < 16; i++)
      shift(lsbMode ? ins[i] : ins[15 - i], r);
    hostDrive = !rd;
    for (int i = 0; i < 8; i++)
    begin
      shift(lsbMode ? wd[i] : wd[7 - i], r);
      q[lsbMode ? i : 7 - i] = r;
    end
    tick(6);
    serialSelectN = 1'b1;
    hostDrive = 1'b0;
    tick(8);
  endtask
  // msb-first write frame of nBits data bits; a part byte cuts the frame
  task automatic write_bits(input logic [12:0] a, input logic [15:0] wd, input int nBits);
    logic [15:0] ins;
    logic [1:0] len;
    logic r;
    len = (nBits > 8) ? 2'h1 : 2'h0;
    ins = {1'b0, len, a};
    serialSelectN = 1'b0;
    hostDrive = 1'b1;
    tick(6);
    for (int i = 0; i < 16; i++)
      shift(ins[15 - i], r);
    for (int i = 0; i < nBits; i++)
      shift(wd[15 - i], r);
    tick(6);
    serialSelectN = 1'b1;
    hostDrive = 1'b0;
    tick(8);
  endtask
endmodule

/* verification/adc_config_register_map_bench.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin testsRun++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module adc_config_register_map_bench;
  localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary identity value
  localparam logic [1:0] GRADE = 2'h2;
  logic clock;
  logic rst;
  logic sclkPin;
  logic serialSelectN;
  logic sdioIn;
  logic sdioOut;
  logic sdioOe;
  logic [9:0] laneFullPowerdown;
  logic [9:0] laneStandby;
  logic [9:0] laneHeldReset;
  logic [9:0] laneContinuousWave;
  logic [9:0] gainPathPowerdown;
  logic [9:0] laneLnaBypass;
  logic dutyCycleStabiliserOn;
  logic [7:0] q;
  logic [9:0] mask;
  logic [20:0] rows [9];
  logic [2:0] codes [6];
  int fails;
  int testsRun;
  acfg_register_map #(.IDENTITY_CODE(ID_CODE), .SPEED_GRADE(GRADE)) acfg_register_map_inst (
    .clock(clock), .rst(rst), .sclkPin(sclkPin), .serialSelectN(serialSelectN),
    .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .laneFullPowerdown(laneFullPowerdown), .laneStandby(laneStandby),
    .laneHeldReset(laneHeldReset), .laneContinuousWave(laneContinuousWave),
    .gainPathPowerdown(gainPathPowerdown), .laneLnaBypass(laneLnaBypass),
    .dutyCycleStabiliserOn(dutyCycleStabiliserOn));
  acfg_host_model acfg_host_model_inst (.clock(clock), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .sclkPin(sclkPin), .serialSelectN(serialSelectN), .sdioIn(sdioIn));
  function automatic logic [9:0] sel(input logic [2:0] c, input logic [2:0] m);
    return (c == m) ? 10'h0ff : 10'h000;
  endfunction
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    acfg_host_model_inst.xfer(1'b0, a, d, x);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    acfg_host_model_inst.xfer(1'b1, a, 8'h00, d);
  endtask
  task automatic check_defaults;
    for (int i = 0; i < 9; i++)
    begin
      rd(rows[i][20:8], q);
      `CHECK(q, rows[i][7:0])
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    fails++;
    end_of_test;
  end
  initial
  begin
    fails = 0;
    testsRun = 0;
    rst = 1'b1;
    rows = '{{13'h0000, 8'h18}, {13'h0001, ID_CODE}, {13'h0002, {2'h0, GRADE, 4'h0}},
      {13'h0003, 8'h00}, {13'h0004, 8'h0f}, {13'h0005, 8'h0f}, {13'h0008, 8'h00},
      {13'h0009, 8'h01}, {13'h00ff, 8'h00}};
    codes = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHECK(dutyCycleStabiliserOn, 1'b1)
    `CHECK(laneFullPowerdown | laneStandby | laneHeldReset | laneContinuousWave, 10'h000)
    check_defaults;
    mask = 10'h000;
    for (int i = 0; i < 6; i++)
    begin
      wr(13'h0008, {5'h00, codes[i]});
      `CHECK(laneFullPowerdown | laneStandby | laneHeldReset | laneContinuousWave, mask)
      wr(13'h00ff, 8'h01);
      `CHECK(laneFullPowerdown, sel(codes[i], acfg_pkg::MODE_FULL_PDWN))
      `CHECK(laneStandby, sel(codes[i], acfg_pkg::MODE_STANDBY))
      `CHECK(laneHeldReset, sel(codes[i], acfg_pkg::MODE_RESET))
      `CHECK(laneContinuousWave, sel(codes[i], acfg_pkg::MODE_CW))
      `CHECK(gainPathPowerdown, sel(codes[i], acfg_pkg::MODE_CW))
      mask = (codes[i] inside {3'h1, 3'h2, 3'h3, 3'h4}) ? 10'h0ff : 10'h000;
    end
    // only the two clock outputs selected
    wr(13'h0004, 8'h00);
    wr(13'h0005, 8'h30);
    wr(13'h0008, 8'h08);
    wr(13'h00ff, 8'h01);
    `CHECK(laneLnaBypass, 10'h300)
    rd(13'h0008, q);
    `CHECK(q, 8'h08)
    rd(13'h0005, q);
    `CHECK(q, 8'h30)
    wr(13'h0009, 8'h00);
    `CHECK(dutyCycleStabiliserOn, 1'b1)
    wr(13'h00ff, 8'h01);
    `CHECK(dutyCycleStabiliserOn, 1'b0)
    rd(13'h00ff, q);
    `CHECK(q, 8'h00)
    // two-byte frame steps the address down, then a cut byte is dropped
    acfg_host_model_inst.write_bits(13'h0005, 16'h210a, 16);
    rd(13'h0004, q);
    `CHECK(q, 8'h0a)
    acfg_host_model_inst.write_bits(13'h0005, 16'h5000, 4);
    rd(13'h0005, q);
    `CHECK(q, 8'h21)
    wr(13'h0008, 8'h01);
    wr(13'h00ff, 8'h01);
    `CHECK(laneFullPowerdown, 10'h2a1)
    `CHECK(laneLnaBypass, 10'h100)
    rd(13'h0008, q);
    `CHECK(q, 8'h01)
    wr(13'h0000, 8'h5a);
    acfg_host_model_inst.lsbMode = 1'b1;
    rd(13'h0000, q);
    `CHECK(q, 8'h5a)
    // soft reset sent in lsb-first order
    wr(13'h0000, 8'h7e);
    acfg_host_model_inst.lsbMode = 1'b0;
    check_defaults;
    `CHECK(dutyCycleStabiliserOn, 1'b1)
    `CHECK(laneLnaBypass, 10'h000)
    wr(13'h0008, 8'h03);
    wr(13'h00ff, 8'h01);
    `CHECK(laneHeldReset, 10'h0ff)
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    `CHECK(laneHeldReset, 10'h000)
    repeat (4) @(posedge clock);
    #1;
    rd(13'h0008, q);
    `CHECK(q, 8'h00)
    end_of_test;
  end
endmodule
